// file: verilog/rssc_refresh_sleep_config_ctrl.v
`timescale 1ns/10ps
`include "rssc_consts.vh"
module rssc_refresh_sleep_config_ctrl #(
  parameter ROW_BITS = 13
) (
  input  wire                clk,
  input  wire                rstn,
  input  wire                chip_select_n,
  input  wire                link_clock,
  input  wire                complement_clock_input,
  input  wire                high_temp,
  input  wire                command_address_phase,
  input  wire                fixed_latency,
  input  wire                cfg_wr_en,
  input  wire [15:0]         cfg_wr_data,
  output wire [15:0]         refresh_sleep_config,
  output reg                 complement_clock_enable,
  output reg                 link_clock_rise,
  output reg                 hybrid_sleep_state,
  output reg                 refresh_busy,
  output reg  [ROW_BITS-1:0] refresh_row,
  output reg                 read_write_strobe_mask_o,
  output reg                 read_write_strobe_mask_oe_n
);

  // Refresh state codes
  localparam ST_IDLE = 1'h0;
  localparam ST_BUSY = 1'h1;

  // Released reset, two stages
  reg        rst_s1_ff;
  reg        rst_s2_ff;
  wire       rst_n;
  // Synchronised pins
  wire [3:0] pin_sync;
  wire       cs_n_s;
  wire       ck_s;
  wire       ckb_s;
  wire       hot_s;
  // Register fields
  reg  [8:0] rsv_ff;
  reg        clk_single_ff;
  reg        sleep_ff;
  reg        nxt_sleep;
  reg  [2:0] region_ff;
  wire [1:0] int_code;
  // Select edge detection
  reg        cs_n_d_ff;
  wire       cs_fall;
  // Link clock edge detection
  reg        lclk_d_ff;
  wire       lclk_lvl;
  // Refresh timing
  reg  [4:0] tick_cnt_ff;
  wire       tick;
  reg  [2:0] int_cnt_ff;
  reg        pending_ff;
  reg        state_ff;
  reg  [1:0] ref_cnt_ff;
  reg  [ROW_BITS-1:0] offs_ff;
  // Extra latency captured at start of an access
  reg        extra_lat_ff;

  // Row address inside the selected region for a running offset
  function [ROW_BITS-1:0] region_row;
    input [2:0]          code;
    input [ROW_BITS-1:0] offs;
    reg   [ROW_BITS-1:0] top;
    begin
      top = {ROW_BITS{1'b1}};
      case (code)
        `RSSC_PAR_BOT_HALF: region_row = offs >> 1;
        `RSSC_PAR_BOT_QTR:  region_row = offs >> 2;
        `RSSC_PAR_BOT_8TH:  region_row = offs >> 3;
        `RSSC_PAR_TOP_HALF: region_row = top - (offs >> 1);
        `RSSC_PAR_TOP_QTR:  region_row = top - (offs >> 2);
        `RSSC_PAR_TOP_8TH:  region_row = top - (offs >> 3);
        default:            region_row = offs;
      endcase
    end
  endfunction

  // Release reset through two flip-flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  // Pins cross into the core clock; select enters inverted so the
  // cleared synchroniser reads as an idle select, with no false fall
  rssc_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .rstn (rst_n),
    .din  ({~chip_select_n, link_clock, complement_clock_input,
            high_temp}),
    .dout (pin_sync)
  );
  assign cs_n_s = ~pin_sync[3];
  assign ck_s   = pin_sync[2];
  assign ckb_s  = pin_sync[1];
  assign hot_s  = pin_sync[0];

  assign lclk_lvl = clk_single_ff ? ck_s : (ck_s & ~ckb_s);

  assign int_code = hot_s ? `RSSC_INT_CODE_HOT : `RSSC_INT_CODE_COOL;

  assign refresh_sleep_config = {rsv_ff, clk_single_ff, sleep_ff,
                                 region_ff, int_code};

  // Falling select, from the synchronised copy only
  assign cs_fall = cs_n_d_ff & ~cs_n_s;

  // Timer tick every microsecond
  assign tick = (tick_cnt_ff == (`RSSC_TICK_CYC - 1));

  // Next hybrid sleep value
  always @* begin
    nxt_sleep = sleep_ff;
    if (cs_fall) begin
      nxt_sleep = 1'b0;
    // write of bit 5 enters sleep
    end else if (cfg_wr_en) begin
      nxt_sleep = cfg_wr_data[`RSSC_SLEEP_BIT];
    end
  end

  // Configuration register; reset also ends sleep
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsv_ff        <= `RSSC_RSV_RST;
      clk_single_ff <= `RSSC_CLKSEL_RST;
      sleep_ff      <= `RSSC_SLEEP_RST;
      region_ff     <= `RSSC_PAR_RST;
    end else begin
      sleep_ff <= nxt_sleep;
      // Writable fields; low bits are never stored
      if (cfg_wr_en) begin
        rsv_ff        <= cfg_wr_data[`RSSC_RSV_HI:`RSSC_RSV_LO];
        clk_single_ff <= cfg_wr_data[`RSSC_CLKSEL_BIT];
        region_ff     <= cfg_wr_data[`RSSC_PAR_HI:`RSSC_PAR_LO];
      end
    end
  end

  // Edge detectors and clock-path outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_d_ff               <= 1'b1;
      lclk_d_ff               <= 1'b0;
      link_clock_rise         <= 1'b0;
      complement_clock_enable <= 1'b0;
      hybrid_sleep_state      <= 1'b0;
    end else begin
      cs_n_d_ff               <= cs_n_s;
      lclk_d_ff               <= lclk_lvl;
      link_clock_rise         <= lclk_lvl & ~lclk_d_ff;
      complement_clock_enable <= ~clk_single_ff;
      hybrid_sleep_state      <= sleep_ff;
    end
  end

  // Interval timer requests one row refresh per interval
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 5'h00;
      int_cnt_ff  <= 3'h0;
      pending_ff  <= 1'b0;
    end else begin
      tick_cnt_ff <= tick ? 5'h00 : tick_cnt_ff + 5'h01;
      if (tick) begin
        if ((hot_s && int_cnt_ff >= (`RSSC_INT_HOT_US - 1)) ||
            (int_cnt_ff >= (`RSSC_INT_COOL_US - 1))) begin
          int_cnt_ff <= 3'h0;
          // no request when region is none
          if (region_ff != `RSSC_PAR_NONE) begin
            pending_ff <= 1'b1;
          end
        end else begin
          int_cnt_ff <= int_cnt_ff + 3'h1;
        end
      end
      // Request taken by the refresh engine
      if (state_ff == ST_IDLE && pending_ff && cs_n_s && !tick) begin
        pending_ff <= 1'b0;
      end
    end
  end

  // Refresh engine starts a row only while select is high
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= ST_IDLE;
      ref_cnt_ff   <= 2'h0;
      offs_ff      <= {ROW_BITS{1'b0}};
      refresh_busy <= 1'b0;
      refresh_row  <= {ROW_BITS{1'b0}};
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // wait for the access to end
          if (pending_ff && cs_n_s && !tick) begin
            state_ff     <= ST_BUSY;
            ref_cnt_ff   <= 2'h0;
            refresh_busy <= 1'b1;
            refresh_row  <= region_row(region_ff, offs_ff);
          end
        end
        ST_BUSY: begin
          if (ref_cnt_ff == (`RSSC_REF_CYC - 1)) begin
            state_ff     <= ST_IDLE;
            refresh_busy <= 1'b0;
            offs_ff      <= offs_ff + {{(ROW_BITS-1){1'b0}}, 1'b1};
          end else begin
            ref_cnt_ff <= ref_cnt_ff + 2'h1;
          end
        end
        default: begin
          state_ff     <= ST_IDLE;
          refresh_busy <= 1'b0;
        end
      endcase
    end
  end

  // Strobe during the command-address phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extra_lat_ff                <= 1'b0;
      read_write_strobe_mask_o    <= 1'b0;
      read_write_strobe_mask_oe_n <= 1'b1;
    end else begin
      if (cs_fall) begin
        extra_lat_ff <= fixed_latency | pending_ff |
                        (state_ff == ST_BUSY);
      end
      read_write_strobe_mask_o    <= command_address_phase &
                                     extra_lat_ff;
      read_write_strobe_mask_oe_n <= ~command_address_phase;
    end
  end

endmodule

// file: verilog/rssc_consts.vh
`ifndef RSSC_CONSTS_VH
`define RSSC_CONSTS_VH

// Clock period of the core clock in ns
`define RSSC_CLK_NS        40
// Base tick of the refresh timer in ns
`define RSSC_TICK_NS       1000
// Cycles per timer tick
`define RSSC_TICK_CYC      ((`RSSC_TICK_NS + `RSSC_CLK_NS - 1) / `RSSC_CLK_NS)
// Refresh interval, cool range, in us
`define RSSC_INT_COOL_US   4
// Refresh interval, hot range, in us
`define RSSC_INT_HOT_US    1
// Time that one row refresh occupies the array, in ns
`define RSSC_REF_NS        80
// Cycles for one row refresh, rounded up
`define RSSC_REF_CYC       ((`RSSC_REF_NS + `RSSC_CLK_NS - 1) / `RSSC_CLK_NS)

// Field positions of the refresh/sleep configuration register
`define RSSC_RSV_HI        15
`define RSSC_RSV_LO        7
`define RSSC_CLKSEL_BIT    6
`define RSSC_SLEEP_BIT     5
`define RSSC_PAR_HI        4
`define RSSC_PAR_LO        2
`define RSSC_INT_HI        1
`define RSSC_INT_LO        0

// Reset values of the fields
`define RSSC_RSV_RST       9'h1ff
`define RSSC_CLKSEL_RST    1'h1
`define RSSC_SLEEP_RST     1'h0
`define RSSC_PAR_RST       3'h0

// Interval codes reported in the low bits
`define RSSC_INT_CODE_COOL 2'h1
`define RSSC_INT_CODE_HOT  2'h2

// Partial refresh region codes
`define RSSC_PAR_FULL      3'h0
`define RSSC_PAR_BOT_HALF  3'h1
`define RSSC_PAR_BOT_QTR   3'h2
`define RSSC_PAR_BOT_8TH   3'h3
`define RSSC_PAR_NONE      3'h4
`define RSSC_PAR_TOP_HALF  3'h5
`define RSSC_PAR_TOP_QTR   3'h6
`define RSSC_PAR_TOP_8TH   3'h7

`endif

// file: verilog/rssc_sync.v
`timescale 1ns/10ps
// Two-stage synchroniser for levels from outside the clock domain
module rssc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  // First stage, read only by the second
  reg [W-1:0] meta_ff;
  // Second stage, safe to use
  reg [W-1:0] sync_ff;

  // Shift the input through both stages
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule

// file: test/rssc_chk_sva.sv
`timescale 1ns/10ps
// Watches register, strobe and refresh outputs
module rssc_chk (
  input wire        clk,
  input wire        rstn,
  input wire        chip_select_n,
  input wire        command_address_phase,
  input wire        fixed_latency,
  input wire        cfg_wr_en,
  input wire [15:0] cfg_wr_data,
  input wire [15:0] refresh_sleep_config,
  input wire        complement_clock_enable,
  input wire        hybrid_sleep_state,
  input wire        refresh_busy,
  input wire        read_write_strobe_mask_o,
  input wire        read_write_strobe_mask_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [15:0] cfg = refresh_sleep_config; // Short alias
  property p_int; cfg[1:0] == 2'h1 || cfg[1:0] == 2'h2; endproperty
  a_int: assert property (p_int) else $error("bad interval code");
  property p_cken;
    $stable(cfg[6])[*3] |-> complement_clock_enable == !cfg[6];
  endproperty
  a_cken: assert property (p_cken) else $error("clock mode");
  property p_enter;
    chip_select_n[*4] ##0 (cfg_wr_en && cfg_wr_data[5]) |=> cfg[5];
  endproperty
  a_enter: assert property (p_enter) else $error("no sleep");
  property p_hs; $rose(cfg[5]) |=> hybrid_sleep_state; endproperty
  a_hs: assert property (p_hs) else $error("sleep state");
  property p_exit; $fell(chip_select_n) && cfg[5] |-> ##[1:4] !cfg[5];
  endproperty
  a_exit: assert property (p_exit) else $error("no wake");
  property p_busy;
    $rose(refresh_busy) |-> refresh_busy ##1 refresh_busy ##1 !refresh_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length");
  // The engine starts on the select level sampled three edges earlier
  property p_idle;
    $rose(refresh_busy) |-> $past(chip_select_n, 3);
  endproperty
  a_idle: assert property (p_idle) else $error("refresh in use");
  property p_oe;
    $rose(command_address_phase) |=> !read_write_strobe_mask_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("strobe idle");
  property p_fix;
    fixed_latency[*8] ##0 command_address_phase |=> read_write_strobe_mask_o;
  endproperty
  a_fix: assert property (p_fix) else $error("fixed strobe");
  property p_ro; cfg_wr_en |=> $stable(cfg[1:0]); endproperty
  a_ro: assert property (p_ro) else $error("ro bits");
  c_wake: cover property ($fell(cfg[5]));
  c_ref: cover property ($rose(refresh_busy));
  c_fix: cover property (command_address_phase && fixed_latency);
  c_lat: cover property (command_address_phase && !fixed_latency &&
    read_write_strobe_mask_o);
endmodule

// file: test/rssc_host.sv
`timescale 1ns/10ps
// Host side: select, clock pair and address phase
module rssc_host (
  input  wire  clk,
  output logic chip_select_n,
  output logic link_clock,
  output wire  complement_clock_input,
  output logic command_address_phase
);
  bit ckb_hi; // Bias complement input high
  initial begin
    chip_select_n = 1;
    link_clock = 0;
    command_address_phase = 0;
  end
  // Link clock toggles only inside frames, off the core phase
  initial begin
    #3;
    forever begin
      #160;
      link_clock = !chip_select_n && !link_clock;
    end
  end
  assign complement_clock_input = ckb_hi | ~link_clock;
  task xfer(input int n);
    @(negedge clk) chip_select_n <= 0;
    repeat (5) @(negedge clk);
    command_address_phase <= 1;
    repeat (3) @(negedge clk);
    command_address_phase <= 0;
    repeat (n) @(negedge clk);
    chip_select_n <= 1;
    @(negedge clk);
  endtask
endmodule

// file: test/tb_refresh_sleep_config_ctrl.sv
`timescale 1ns/10ps
module tb_refresh_sleep_config_ctrl;
  logic clk, rstn, high_temp, fixed_latency, cfg_wr_en;
  logic [15:0] cfg_wr_data;
  wire csn, lck, ckb, ca, ce, rise, hs, busy, rws, rws_oe_n;
  wire [15:0] cfg;
  wire [12:0] row;
  logic [12:0] last_row;
  int failures, check_count, rises, refs;
  rssc_host host (.clk(clk), .chip_select_n(csn), .link_clock(lck),
    .complement_clock_input(ckb), .command_address_phase(ca));
  rssc_refresh_sleep_config_ctrl dut (.clk(clk), .rstn(rstn),
    .chip_select_n(csn), .link_clock(lck), .complement_clock_input(ckb),
    .high_temp(high_temp), .command_address_phase(ca),
    .fixed_latency(fixed_latency), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_data(cfg_wr_data), .refresh_sleep_config(cfg),
    .complement_clock_enable(ce), .link_clock_rise(rise),
    .hybrid_sleep_state(hs), .refresh_busy(busy), .refresh_row(row),
    .read_write_strobe_mask_o(rws), .read_write_strobe_mask_oe_n(rws_oe_n));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Count rises and busy cycles, keep last row
  always @(posedge clk) begin
    if (rise) rises++;
    if (busy) begin
      refs++;
      last_row <= row;
    end
  end
  task chk(input string n, input logic [15:0] e, v);
    check_count++;
    if (v !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task wr(input logic [15:0] d);
    @(negedge clk) cfg_wr_en <= 1;
    cfg_wr_data <= d;
    @(negedge clk) cfg_wr_en <= 0;
    repeat (3) @(negedge clk);
  endtask
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    final_report;
  end
  initial begin
    rstn = 0;
    high_temp = 0;
    fixed_latency = 1;
    cfg_wr_en = 0;
    cfg_wr_data = 0;
    repeat (10) @(negedge clk);
    rstn = 1;
    repeat (5) @(negedge clk);
    chk("cfg", 16'hffc1, cfg);
    chk("ck_en", 0, ce);
    $display("test reset done");
    for (int r = 0; r < 8; r++) begin
      wr({10'h3ff, 1'b0, r[2:0], 2'h0});
      chk("cfg", {10'h3ff, 1'b0, r[2:0], 2'h1}, cfg);
      repeat (20) @(negedge clk);
      refs = 0;
      repeat (230) @(negedge clk);
      chk("refs", r != 4, refs >= 4 && refs <= 6);
      if (r % 4 != 0)
        chk("row", r > 4 ? (16'h1 << r[1:0]) - 1 : 0,
          16'(last_row >> (13 - r[1:0])));
    end
    $display("test regions done");
    high_temp = 1;
    repeat (10) @(negedge clk);
    chk("cfg_hot", 16'hffde, cfg);
    refs = 0;
    repeat (200) @(negedge clk);
    chk("refs_hot", 1, refs >= 14 && refs <= 18);
    high_temp = 0;
    repeat (10) @(negedge clk);
    $display("test hot done");
    wr(16'hffe0);
    chk("hs", 1, hs);
    refs = 0;
    repeat (120) @(negedge clk);
    chk("sleep_ref", 1, refs > 0);
    host.xfer(10);
    chk("wake", 16'hffc1, cfg);
    chk("hs_wake", 0, hs);
    wr(16'hffe0);
    chk("hs_pre", 1, hs);
    rstn = 0;
    repeat (2) @(negedge clk);
    rstn = 1;
    repeat (5) @(negedge clk);
    chk("cfg_rst", 16'hffc1, cfg);
    chk("hs_rst", 0, hs);
    $display("test sleep done");
    host.ckb_hi = 1;
    rises = 0;
    host.xfer(10);
    chk("single", 1, rises > 0);
    wr(16'hff80);
    chk("ck_en", 1, ce);
    rises = 0;
    host.xfer(10);
    chk("biased", 0, rises);
    host.ckb_hi = 0;
    rises = 0;
    host.xfer(10);
    chk("diff", 1, rises > 0);
    $display("test clock done");
    for (int f = 1; f >= 0; f--) begin
      if (f == 0) wr(16'hffd0);
      fixed_latency = f[0];
      repeat (150) @(negedge clk);
      fork
        host.xfer(10);
        begin
          repeat (8) @(negedge clk);
          chk("rws", f, rws);
          chk("oe_n", 0, rws_oe_n);
        end
      join
    end
    // A refresh falls due inside a long frame; the next access waits
    wr(16'hffc0);
    @(posedge busy);
    repeat (40) @(negedge clk);
    host.xfer(70);
    fork
      host.xfer(10);
      begin
        repeat (8) @(negedge clk);
        chk("rws_ref", 1, rws);
        chk("oe_n_ref", 0, rws_oe_n);
      end
    join
    $display("test strobe done");
    final_report;
  end
endmodule
bind rssc_refresh_sleep_config_ctrl rssc_chk u_chk (
  .clk                         (clk),
  .rstn                        (rstn),
  .chip_select_n               (chip_select_n),
  .command_address_phase       (command_address_phase),
  .fixed_latency               (fixed_latency),
  .cfg_wr_en                   (cfg_wr_en),
  .cfg_wr_data                 (cfg_wr_data),
  .refresh_sleep_config        (refresh_sleep_config),
  .complement_clock_enable     (complement_clock_enable),
  .hybrid_sleep_state          (hybrid_sleep_state),
  .refresh_busy                (refresh_busy),
  .read_write_strobe_mask_o    (read_write_strobe_mask_o),
  .read_write_strobe_mask_oe_n (read_write_strobe_mask_oe_n)
);
